// ### hdl/eeprom_consts.vh
// Constants for the two-wire serial memory slave
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_MHZ            125
`define PROGRAM_CYCLE_TIME_MS  10
`define POWERUP_READ_DELAY_MS  1
`define POWERUP_WRITE_DELAY_MS 1
`define CNT_W                  24

// ----------------------------------------------------------------
// Array and address layout (512-byte density, two select pins)
// ----------------------------------------------------------------
`define MEM_AW                 9
`define MEM_WORDS              512
`define PAGE_AW                4
`define PAGE_BYTES             16
`define HI_W                   1
`define DEV_CODE               4'hA
`define SEL_MASK               3'h6

// ----------------------------------------------------------------
// Byte kinds within a transfer
// ----------------------------------------------------------------
`define KIND_SLAVE             2'h0
`define KIND_WORD              2'h1
`define KIND_DATA              2'h2

`endif

// ### hdl/line_sync.v
// Two-stage synchroniser for asynchronous input levels
`timescale 1ns/1ps
module line_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage1;

  always @(posedge clk) begin
    if (rst) begin
      stage1 <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ### hdl/fifo2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module fifo2 (
  input  wire       clk,
  input  wire       rst,
  input  wire       flush,
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_data,
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data
);
  reg [7:0] slot [0:1];
  reg       wr_ptr;
  reg       rd_ptr;
  reg [1:0] count;
  wire      push;
  wire      pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

// ### hdl/eeprom_slave.v
// Two-wire serial memory slave: bus engine, page buffer and array
`timescale 1ns/1ps
`include "eeprom_consts.vh"
module eeprom_slave #(
  parameter PROG_CYCLES    = `PROGRAM_CYCLE_TIME_MS * 1000 * `REF_CLK_MHZ,
  parameter POWERUP_CYCLES = ((`POWERUP_READ_DELAY_MS < `POWERUP_WRITE_DELAY_MS) ?
                              `POWERUP_READ_DELAY_MS : `POWERUP_WRITE_DELAY_MS) * 1000 * `REF_CLK_MHZ
) (
  input  wire REF_CLK,
  input  wire SYS_RST,
  input  wire SCL,
  input  wire SDA_IN,
  output reg  SDA_OUT,
  output reg  SDA_OE_N,
  input  wire SELECT_PIN_0,
  input  wire SELECT_PIN_1,
  input  wire SELECT_PIN_2,
  input  wire WRITE_PROTECT,
  output reg  BUSY
);

  // ----------------------------------------------------------------
  // States and limits
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RX   = 6'h02;
  localparam [5:0] S_ACK  = 6'h04;
  localparam [5:0] S_TX   = 6'h08;
  localparam [5:0] S_RACK = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  // Limits are worked out at 32 bits, then cut to the counter width on purpose
  localparam [31:0]       PROG_LIM_W = PROG_CYCLES - 1;
  localparam [31:0]       PU_LIM_W   = POWERUP_CYCLES - 1;
  localparam [`CNT_W-1:0] PROG_LIM   = PROG_LIM_W[`CNT_W-1:0];
  localparam [`CNT_W-1:0] PU_LIM     = PU_LIM_W[`CNT_W-1:0];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire [1:0]             bus_s;
  wire [3:0]             pin_s;
  wire                   scl_s;
  wire                   sda_s;
  wire                   wp_s;
  wire [2:0]             sel_s;
  reg                    scl_p;
  reg                    sda_p;
  wire                   scl_rise;
  wire                   scl_fall;
  wire                   start_c;
  wire                   stop_c;

  reg  [5:0]             state;
  reg  [3:0]             bit_cnt;
  reg  [7:0]             rx_sh;
  reg  [7:0]             tx_sh;
  reg  [1:0]             kind;
  reg                    read_dir;
  reg                    master_ack;
  reg  [`MEM_AW-1:0]     ptr;
  reg  [`MEM_AW-1:0]     pre_ptr;
  reg  [`MEM_AW-1:0]     commit_base;
  reg  [7:0]             pbuf [0:`PAGE_BYTES-1];
  reg  [`PAGE_BYTES-1:0] pvalid;
  reg                    wr_pending;
  reg                    commit;
  reg                    pop;
  reg                    ready;
  reg  [`CNT_W-1:0]      pu_cnt;
  reg  [`CNT_W-1:0]      prog_cnt;
  reg  [7:0]             mem [0:`MEM_WORDS-1];

  wire                   fill_valid;
  wire                   fill_ready;
  wire [7:0]             fill_data;
  wire                   buf_valid;
  wire [7:0]             buf_data;
  integer                i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The unused select pin 0 is don't-care here; its address bit picks the array half on write-direction slave bytes only
  function addr_match;
    input [7:0] b;
    input [2:0] pins;
    begin
      addr_match = (b[7:4] == `DEV_CODE) &&
                   ((b[3:1] & `SEL_MASK) == (pins & `SEL_MASK));
    end
  endfunction

  // Increment inside the page only; upper bits stay put
  function [`MEM_AW-1:0] page_inc;
    input [`MEM_AW-1:0] a;
    begin
      page_inc = {a[`MEM_AW-1:`PAGE_AW], a[`PAGE_AW-1:0] + 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and condition detection
  // ----------------------------------------------------------------
  line_sync #(.W(2)) u_bus_sync (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .din  ({SCL, SDA_IN}),
    .dout (bus_s)
  );

  line_sync #(.W(4)) u_pin_sync (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .din  ({WRITE_PROTECT, SELECT_PIN_2, SELECT_PIN_1, SELECT_PIN_0}),
    .dout (pin_s)
  );

  assign scl_s    = bus_s[1];
  assign sda_s    = bus_s[0];
  assign wp_s     = pin_s[3];
  assign sel_s    = pin_s[2:0];
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;

  // ----------------------------------------------------------------
  // Read prefetch
  // ----------------------------------------------------------------
  // Two bytes are fetched ahead so the shifter never waits on the array;
  // every start flushes them since the pointer may have moved.
  assign fill_data  = mem[pre_ptr];
  assign fill_valid = ready & ~BUSY & ~start_c;

  fifo2 u_prefetch (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .flush     (start_c),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (fill_data),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  // ----------------------------------------------------------------
  // Array commit
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (commit) begin
      for (i = 0; i < `PAGE_BYTES; i = i + 1) begin
        if (pvalid[i]) begin
          mem[{commit_base[`MEM_AW-1:`PAGE_AW], i[`PAGE_AW-1:0]}] <= pbuf[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (state == S_RX && scl_fall && bit_cnt == 4'h8 && kind == `KIND_DATA && !wp_s) begin
      pbuf[ptr[`PAGE_AW-1:0]] <= rx_sh;
    end
  end

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      scl_p       <= 1'b1;
      sda_p       <= 1'b1;
      state       <= S_IDLE;
      bit_cnt     <= 4'h0;
      rx_sh       <= 8'h00;
      tx_sh       <= 8'h00;
      kind        <= `KIND_SLAVE;
      read_dir    <= 1'b0;
      master_ack  <= 1'b0;
      ptr         <= {`MEM_AW{1'b0}};
      pre_ptr     <= {`MEM_AW{1'b0}};
      commit_base <= {`MEM_AW{1'b0}};
      pvalid      <= {`PAGE_BYTES{1'b0}};
      wr_pending  <= 1'b0;
      commit      <= 1'b0;
      pop         <= 1'b0;
      ready       <= 1'b0;
      pu_cnt      <= {`CNT_W{1'b0}};
      prog_cnt    <= {`CNT_W{1'b0}};
      SDA_OUT     <= 1'b0;
      SDA_OE_N    <= 1'b1;
      BUSY        <= 1'b0;
    end else begin
      scl_p  <= scl_s;
      sda_p  <= sda_s;
      commit <= 1'b0;
      pop    <= 1'b0;

      // Interface stays deaf until the power-up delay has run out
      if (!ready) begin
        if (pu_cnt == PU_LIM) begin
          ready <= 1'b1;
        end else begin
          pu_cnt <= pu_cnt + 1'b1;
        end
      end

      if (BUSY) begin
        if (prog_cnt == PROG_LIM) begin
          BUSY <= 1'b0;
        end else begin
          prog_cnt <= prog_cnt + 1'b1;
        end
      end

      if (start_c) begin
        pre_ptr <= ptr;
      end else if (fill_valid && fill_ready) begin
        pre_ptr <= pre_ptr + 1'b1;
      end

      if (!ready || BUSY) begin
        // Polling during programming sees a released line, no ack
        state    <= S_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (start_c) begin
        // A repeated start also drops any unfinished page
        state      <= S_RX;
        bit_cnt    <= 4'h0;
        kind       <= `KIND_SLAVE;
        SDA_OE_N   <= 1'b1;
        pvalid     <= {`PAGE_BYTES{1'b0}};
        wr_pending <= 1'b0;
      end else if (stop_c) begin
        state    <= S_IDLE;
        SDA_OE_N <= 1'b1;
        if (wr_pending) begin
          commit      <= 1'b1;
          commit_base <= ptr;
          BUSY        <= 1'b1;
          prog_cnt    <= {`CNT_W{1'b0}};
          wr_pending  <= 1'b0;
        end
      end else begin
        case (state)
          S_RX: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              rx_sh   <= {rx_sh[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              case (kind)
                `KIND_SLAVE: begin
                  if (addr_match(rx_sh, sel_s)) begin
                    SDA_OE_N <= 1'b0;
                    state    <= S_ACK;
                    read_dir <= rx_sh[0];
                    if (!rx_sh[0]) begin
                      ptr[`MEM_AW-1:8] <= rx_sh[`HI_W:1];
                    end
                  end else begin
                    state <= S_WAIT;
                  end
                end
                `KIND_WORD: begin
                  ptr[7:0] <= rx_sh;
                  SDA_OE_N <= 1'b0;
                  state    <= S_ACK;
                end
                default: begin
                  if (wp_s) begin
                    state <= S_WAIT;
                  end else begin
                    pvalid[ptr[`PAGE_AW-1:0]] <= 1'b1;
                    ptr        <= page_inc(ptr);
                    wr_pending <= 1'b1;
                    SDA_OE_N   <= 1'b0;
                    state      <= S_ACK;
                  end
                end
              endcase
            end
          end

          S_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (read_dir) begin
                tx_sh    <= {buf_data[6:0], 1'b0};
                SDA_OE_N <= buf_data[7];
                pop      <= 1'b1;
                ptr      <= ptr + 1'b1;
                state    <= S_TX;
              end else begin
                SDA_OE_N <= 1'b1;
                state    <= S_RX;
                kind     <= (kind == `KIND_SLAVE) ? `KIND_WORD : `KIND_DATA;
              end
            end
          end

          S_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                SDA_OE_N <= 1'b1;
                state    <= S_RACK;
              end else begin
                SDA_OE_N <= tx_sh[7];
                tx_sh    <= {tx_sh[6:0], 1'b0};
              end
            end
          end

          S_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (master_ack) begin
                tx_sh    <= {buf_data[6:0], 1'b0};
                SDA_OE_N <= buf_data[7];
                pop      <= 1'b1;
                ptr      <= ptr + 1'b1;
                state    <= S_TX;
              end else begin
                state <= S_WAIT;
              end
            end
          end

          S_WAIT: begin
            SDA_OE_N <= 1'b1;
          end

          S_IDLE: begin
            SDA_OE_N <= 1'b1;
          end

          default: begin
            state    <= S_IDLE;
            SDA_OE_N <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// ### verif/eeprom_slave_sva.sv
// Port checker for the two-wire serial memory slave
`timescale 1ns/1ps
module eeprom_slave_chk #(
  parameter PROG_CYCLES    = 200,
  parameter POWERUP_CYCLES = 20
) (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire SCL,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE_N,
  input wire WRITE_PROTECT,
  input wire BUSY
);
  reg        scl_q;
  reg        sda_q;
  reg        in_frame;
  reg        wp_seen;
  reg [7:0]  since_stop;
  reg [31:0] busy_cnt;
  reg [31:0] pu_cnt;
  wire       start_ev = scl_q & SCL & sda_q & ~SDA_IN;
  wire       stop_ev  = scl_q & SCL & ~sda_q & SDA_IN;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  // -----------------------------------------------------------
  // Bus condition tracking
  // -----------------------------------------------------------
  always @(posedge REF_CLK) begin
    scl_q <= SCL;
    sda_q <= SDA_IN;
    if (SYS_RST) begin
      in_frame   <= 1'b0;
      wp_seen    <= 1'b0;
      since_stop <= 8'hFF;
      busy_cnt   <= 32'h0;
      pu_cnt     <= 32'h0;
    end else begin
      in_frame   <= start_ev | (in_frame & ~stop_ev);
      wp_seen    <= start_ev ? WRITE_PROTECT : (wp_seen | WRITE_PROTECT);
      since_stop <= stop_ev ? 8'h00 : since_stop + {7'h0, since_stop != 8'hFF};
      busy_cnt   <= BUSY ? busy_cnt + 32'h1 : 32'h0;
      pu_cnt     <= pu_cnt + {31'h0, pu_cnt < POWERUP_CYCLES};
    end
  end

  // Reset itself is the antecedent, so this one is never disabled
  property p_reset_idle;
    @(posedge REF_CLK) disable iff (1'b0) SYS_RST |=> SDA_OE_N && !BUSY;
  endproperty
  property p_open_drain;     SDA_OUT == 1'b0;                    endproperty
  property p_quiet_powerup;  pu_cnt < POWERUP_CYCLES |-> SDA_OE_N; endproperty
  property p_start_first;    !SDA_OE_N |-> in_frame;             endproperty
  property p_busy_released;  BUSY |-> SDA_OE_N;                  endproperty
  property p_busy_after_stop; $rose(BUSY) |-> since_stop < 8'h10; endproperty
  property p_busy_length;
    $fell(BUSY) |-> busy_cnt <= PROG_CYCLES && busy_cnt + 4 >= PROG_CYCLES;
  endproperty
  property p_one_cycle;      $rose(BUSY) |=> BUSY [*8];          endproperty
  property p_protect;        $rose(BUSY) |-> !wp_seen;           endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");
  a_quiet_powerup: assert property (p_quiet_powerup) else $error("ack during power-up delay");
  a_start_first: assert property (p_start_first) else $error("line pulled outside a frame");
  a_busy_released: assert property (p_busy_released) else $error("line pulled while programming");
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("programming not started by stop");
  a_busy_length: assert property (p_busy_length) else $error("programming time wrong");
  a_one_cycle: assert property (p_one_cycle) else $error("programming cycle broken up");
  a_protect: assert property (p_protect) else $error("protected write programmed");

  c_program: cover property ($rose(BUSY));
  c_ack: cover property ($fell(SDA_OE_N));
  c_poll_busy: cover property (BUSY && start_ev);
endmodule

bind eeprom_slave eeprom_slave_chk #(.PROG_CYCLES(PROG_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES)) chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_N(SDA_OE_N), .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));

// ### verif/i2c_master_model.sv
// Behavioural two-wire bus master facing the memory slave
`timescale 1ns/1ps
module i2c_master_model (
  output reg  scl,
  output reg  sda_pull,
  input  wire sda
);
  reg framed;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    framed   = 1'b0;
  end

  // -----------------------------------------------------------
  // Bit, condition and byte tasks
  // -----------------------------------------------------------
  // Data moves late in the low phase, after the slave has answered
  task bit_io(input v, output r);
    begin
      scl = 1'b0;
      #44 sda_pull = ~v;
      #12 scl = 1'b1;
      #12 r = sda;
      #12;
    end
  endtask

  task start;
    begin
      if (framed) begin
        scl = 1'b0;
        #44 sda_pull = 1'b0;
        #12 scl = 1'b1;
        #40;
      end
      sda_pull = 1'b1;
      #40;
      framed = 1'b1;
    end
  endtask

  task stop;
    begin
      scl = 1'b0;
      #44 sda_pull = 1'b1;
      #12 scl = 1'b1;
      #40 sda_pull = 1'b0;
      #40;
      framed = 1'b0;
    end
  endtask

  task wbyte(input [7:0] b, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask

  task rbyte(input last, output [7:0] b);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(1'b1, b[i]);
      bit_io(last, r);
    end
  endtask
endmodule

// ### verif/eeprom_slave_test.sv
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
module eeprom_slave_test;
  localparam PROG = 200;
  localparam PU   = 200;
  reg        REF_CLK       = 1'b0;
  reg        SYS_RST       = 1'b1;
  reg        WRITE_PROTECT = 1'b0;
  wire       scl;
  wire       sda_pull;
  wire       SDA_OUT;
  wire       SDA_OE_N;
  wire       BUSY;
  wire       sda_line = ~(sda_pull | (~SDA_OE_N & ~SDA_OUT));
  integer    err_count  = 0;
  integer    n_compared = 0;
  reg        ack;
  reg  [7:0] d;
  reg  [7:0] expm [0:511];

  eeprom_slave #(.PROG_CYCLES(PROG), .POWERUP_CYCLES(PU)) uut (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .SELECT_PIN_0(1'b1), .SELECT_PIN_1(1'b0), .SELECT_PIN_2(1'b1),
    .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));
  i2c_master_model m (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));

  initial begin
    forever #4 REF_CLK = ~REF_CLK;
  end

  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task check(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task wr_byte(input [7:0] b, input exp);
    begin
      m.wbyte(b, ack);
      check("ack", {7'h0, exp}, {7'h0, ack});
    end
  endtask

  // First attempt lands inside the program time and must be refused
  task poll;
    integer i;
    reg     first;
    begin
      ack   = 1'b0;
      first = 1'b1;
      for (i = 0; i < 8 && !ack; i = i + 1) begin
        m.start;
        m.wbyte(8'hA8, ack);
        m.stop;
        if (i == 0) first = ack;
      end
      check("poll_nak", 8'h00, {7'h0, first});
      check("poll", 8'h01, {7'h0, ack});
    end
  endtask

  // Selective read of n-1 bytes, then one read from the counter alone
  task rd(input [8:0] a, input integer n);
    integer j;
    begin
      m.start;
      wr_byte({6'h2A, a[8], 1'b0}, 1'b1);
      wr_byte(a[7:0], 1'b1);
      m.start;
      wr_byte(8'hA9, 1'b1);
      for (j = 0; j < n - 1; j = j + 1) begin
        m.rbyte(j == n - 2, d);
        check("rdata", expm[(a + j) & 32'h1FF], d);
      end
      m.stop;
      m.start;
      wr_byte(8'hA9, 1'b1);
      m.rbyte(1'b1, d);
      check("next", expm[(a + n - 1) & 32'h1FF], d);
      m.stop;
    end
  endtask

  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task t_powerup;
    begin
      check("oe_n", 8'h01, {7'h0, SDA_OE_N});
      check("busy", 8'h00, {7'h0, BUSY});
      m.start;
      wr_byte(8'hA8, 1'b0);
      m.stop;
      repeat (PU) @(posedge REF_CLK);
    end
  endtask

  task t_page;
    integer i;
    begin
      m.start;
      wr_byte(8'hA8, 1'b1);
      wr_byte(8'h0E, 1'b1);
      for (i = 0; i < 17; i = i + 1) begin
        wr_byte(8'h40 + i[7:0], 1'b1);
        expm[(14 + i) % 16] = 8'h40 + i[7:0];
      end
      m.stop;
      poll;
      rd(9'h000, 16);
    end
  endtask

  task t_byte;
    begin
      m.start;
      wr_byte(8'hAA, 1'b1);
      wr_byte(8'hFF, 1'b1);
      wr_byte(8'hA5, 1'b1);
      expm[511] = 8'hA5;
      m.stop;
      repeat (8) @(posedge REF_CLK);
      check("busy", 8'h01, {7'h0, BUSY});
      poll;
      rd(9'h1FF, 2);
    end
  endtask

  task t_bad_addr;
    reg [23:0] codes;
    integer    k;
    begin
      codes = 24'hB8A0AC;
      for (k = 0; k < 3; k = k + 1) begin
        m.start;
        wr_byte(codes[23 - 8 * k -: 8], 1'b0);
        m.stop;
      end
    end
  endtask

  task t_protect;
    begin
      @(posedge REF_CLK);
      #1 WRITE_PROTECT = 1'b1;
      m.start;
      wr_byte(8'hAA, 1'b1);
      wr_byte(8'hFF, 1'b1);
      wr_byte(8'h3C, 1'b0);
      m.stop;
      repeat (20) @(posedge REF_CLK);
      check("busy", 8'h00, {7'h0, BUSY});
      #1 WRITE_PROTECT = 1'b0;
      rd(9'h1FF, 2);
    end
  endtask

  // A repeated start drops the unstopped page, so nothing is programmed
  task t_abort;
    begin
      m.start;
      wr_byte(8'hAA, 1'b1);
      wr_byte(8'hFF, 1'b1);
      wr_byte(8'h77, 1'b1);
      m.start;
      wr_byte(8'hB8, 1'b0);
      m.stop;
      repeat (20) @(posedge REF_CLK);
      check("busy", 8'h00, {7'h0, BUSY});
      rd(9'h1FF, 2);
    end
  endtask

  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (12) @(posedge REF_CLK);
    #1 SYS_RST = 1'b0;
    t_powerup;
    t_page;
    t_byte;
    t_bad_addr;
    t_protect;
    t_abort;
    conclude;
  end

  // Run needs about 62 us; a hang is cut well before the cycle budget
  initial begin
    #400000;
    err_count = err_count + 1;
    conclude;
  end
endmodule
